// ### verilog/touch_adc_defines.svh
// touch_adc_defines.svh: offsets, field positions, reset values and timing figures
// assumes: included by its bare name from touch_adc_control only; the package does not include it
`ifndef TOUCH_ADC_DEFINES_SVH
`define TOUCH_ADC_DEFINES_SVH

// register location behind the serial port
`define CTRL_PAGE 2'h1
`define CTRL_ADDR 6'h00

// field positions of converter_control
`define PSM_BIT 15
`define STS_BIT 14
`define FUNC_HI 13
`define FUNC_LO 10
`define RES_HI 9
`define RES_LO 8
`define AVG_HI 7
`define AVG_LO 6
`define CLK_HI 5
`define CLK_LO 4
`define PV_HI 3
`define PV_LO 1

// reset values of the stored fields
`define FUNC_RST 4'h0
`define RES_RST 2'h0
`define AVG_RST 2'h0
`define CLK_RST 2'h0
`define PV_RST 3'h0

// timing: clock period and settling times in ns
`define CLK_PERIOD_NS 20
`define SETTLE_1_NS 100000
`define SETTLE_2_NS 500000
`define SETTLE_3_NS 1000000
`define SETTLE_4_NS 5000000
`define SETTLE_5_NS 10000000
`define SETTLE_6_NS 50000000
`define SETTLE_7_NS 100000000

`endif

// ### verilog/touch_adc_pkg.sv
// touch_adc_pkg: types shared by the converter control block
// assumes: needs no constants from touch_adc_defines.svh
package touch_adc_pkg;

  // page-0 result slots, also used as converter input select
  typedef enum logic [3:0] {
    CH_X = 4'h0,
    CH_Y = 4'h1,
    CH_Z1 = 4'h2,
    CH_Z2 = 4'h3,
    CH_BAT1 = 4'h4,
    CH_BAT2 = 4'h5,
    CH_AUX1 = 4'h6,
    CH_AUX2 = 4'h7,
    CH_TEMP1 = 4'h8,
    CH_TEMP2 = 4'h9
  } chan_type;

  // panel driver selection
  typedef enum logic [1:0] {
    DRV_OFF = 2'h0,
    DRV_X = 2'h1,
    DRV_Y = 2'h2,
    DRV_YX = 2'h3
  } drv_type;

endpackage : touch_adc_pkg

// ### verilog/meas_if.sv
// meas_if: one measurement request between sequencer and sample unit
// assumes: both ends on the same clock
`timescale 1ns/1ns
`default_nettype none

interface meas_if;
  import touch_adc_pkg::*;
  logic req;
  logic abort;
  chan_type chan;
  logic [1:0] avg_sel;
  logic [1:0] res_sel;
  logic [2:0] settle_sel;
  logic done;
  logic [15:0] result;

  modport seq (output req, abort, chan, avg_sel, res_sel, settle_sel, input done, result);
  modport unit (input req, abort, chan, avg_sel, res_sel, settle_sel, output done, result);
endinterface : meas_if

`default_nettype wire

// ### verilog/sample_unit.sv
// sample_unit: settling wait, repeated conversions, averaging and resolution trim
// assumes: converter answers conv_start with conv_done one or more clocks later
`timescale 1ns/1ns
`default_nettype none

module sample_unit
  import touch_adc_pkg::*;
#(
  parameter int unsigned SETTLE_CYC_1 = 1,
  parameter int unsigned SETTLE_CYC_2 = 1,
  parameter int unsigned SETTLE_CYC_3 = 1,
  parameter int unsigned SETTLE_CYC_4 = 1,
  parameter int unsigned SETTLE_CYC_5 = 1,
  parameter int unsigned SETTLE_CYC_6 = 1,
  parameter int unsigned SETTLE_CYC_7 = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // request from sequencer
  meas_if.unit m,
  // converter
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [11:0] conv_data
);

  typedef enum logic [1:0] {U_IDLE, U_SETTLE, U_START, U_WAIT} ustate_type;

  ustate_type state_ff, nxt_state;
  logic [31:0] cnt_ff, nxt_cnt;
  logic [4:0] left_ff, nxt_left;
  logic [15:0] acc_ff, nxt_acc;
  logic [15:0] res_ff, nxt_res;
  logic done_ff, nxt_done;
  logic [15:0] avg_val;
  logic [15:0] sum;

  // settling time table in cycles; code 0 means no wait
  function automatic logic [31:0] settle_cyc(input logic [2:0] sel);
    case (sel)
      3'h1: settle_cyc = 32'(SETTLE_CYC_1);
      3'h2: settle_cyc = 32'(SETTLE_CYC_2);
      3'h3: settle_cyc = 32'(SETTLE_CYC_3);
      3'h4: settle_cyc = 32'(SETTLE_CYC_4);
      3'h5: settle_cyc = 32'(SETTLE_CYC_5);
      3'h6: settle_cyc = 32'(SETTLE_CYC_6);
      3'h7: settle_cyc = 32'(SETTLE_CYC_7);
      default: settle_cyc = 32'h0;
    endcase
  endfunction : settle_cyc

  // the result must include the sample arriving now, so average the running sum, not the register
  assign sum = acc_ff + {4'h0, conv_data};

  // average by shift: 1, 4, 8 or 16 samples summed into 16 bits never overflow
  always_comb begin
    case (m.avg_sel)
      2'h1: avg_val = sum >> 2;
      2'h2: avg_val = sum >> 3;
      2'h3: avg_val = sum >> 4;
      default: avg_val = sum;
    endcase
  end

  assign conv_start = (state_ff == U_START);
  assign m.done = done_ff;
  assign m.result = res_ff;

  // next-state logic of the sample sequence
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_left = left_ff;
    nxt_acc = acc_ff;
    nxt_res = res_ff;
    nxt_done = 1'b0;
    case (state_ff)
      U_IDLE: begin
        if (m.req) begin
          nxt_acc = 16'h0000;
          case (m.avg_sel) // R11
            2'h1: nxt_left = 5'h04;
            2'h2: nxt_left = 5'h08;
            2'h3: nxt_left = 5'h10;
            default: nxt_left = 5'h01;
          endcase
          nxt_cnt = settle_cyc(m.settle_sel); // R12
          nxt_state = (settle_cyc(m.settle_sel) == 32'h0) ? U_START : U_SETTLE;
        end
      end
      U_SETTLE: begin
        nxt_cnt = cnt_ff - 32'h1;
        if (cnt_ff <= 32'h1) begin
          nxt_state = U_START;
        end
      end
      U_START: begin
        nxt_state = U_WAIT;
      end
      U_WAIT: begin
        if (conv_done) begin
          nxt_acc = sum;
          nxt_left = left_ff - 5'h01;
          // busy holds until the last sample of the average is in
          nxt_state = (left_ff == 5'h01) ? U_IDLE : U_START; // R11
          if (left_ff == 5'h01) begin
            nxt_done = 1'b1;
          end
        end
      end
      default: nxt_state = U_IDLE;
    endcase
    // trim result once the accumulator is final
    if (state_ff == U_WAIT && nxt_state == U_IDLE) begin
      case (m.res_sel) // R10
        2'h1: nxt_res = {8'h00, avg_val[11:4]};
        2'h2: nxt_res = {6'h00, avg_val[11:2]};
        default: nxt_res = {4'h0, avg_val[11:0]};
      endcase
    end
    if (m.abort) begin
      nxt_state = U_IDLE; // R06
      nxt_done = 1'b0;
    end
  end

  // state registers; ce low freezes everything
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= U_IDLE;
      cnt_ff <= 32'h0;
      left_ff <= 5'h00;
      acc_ff <= 16'h0000;
      res_ff <= 16'h0000;
      done_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      left_ff <= nxt_left;
      acc_ff <= nxt_acc;
      res_ff <= nxt_res;
      done_ff <= nxt_done;
    end
  end

endmodule : sample_unit

`default_nettype wire

// ### verilog/touch_adc_control.sv
// touch_adc_control: control register, scan sequencer and result routing
// assumes: the serial port front end turns frames into page/address strobes
// on clk; converter and result store sit on clk; pen detect is a raw pin
// Functional notes
// (R01) pen bit reads current touch state
// (R02) pen bit write picks host or self sequencing
// (R03) status bit reads zero while converter busy
// (R04) status bit reads one after reset
// (R05) writing zero keeps scans repeating while touched
// (R06) writing one aborts all and powers down
// (R07) results routed to slot of selected function
// (R08) read shows status where write takes command
// (R09) function code zero updates nothing
// (R10) resolution code selects 12, 8, 10 bits
// (R11) averaging 1/4/8/16, busy until all done
// (R12) self mode drives panel, waits settle delay
// (R13) new scan only while pen down, no stop
`include "touch_adc_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module touch_adc_control
  import touch_adc_pkg::*;
#(
  parameter int unsigned SETTLE_CYC_1 = `SETTLE_1_NS / `CLK_PERIOD_NS,
  parameter int unsigned SETTLE_CYC_2 = `SETTLE_2_NS / `CLK_PERIOD_NS,
  parameter int unsigned SETTLE_CYC_3 = `SETTLE_3_NS / `CLK_PERIOD_NS,
  parameter int unsigned SETTLE_CYC_4 = `SETTLE_4_NS / `CLK_PERIOD_NS,
  parameter int unsigned SETTLE_CYC_5 = `SETTLE_5_NS / `CLK_PERIOD_NS,
  parameter int unsigned SETTLE_CYC_6 = `SETTLE_6_NS / `CLK_PERIOD_NS,
  parameter int unsigned SETTLE_CYC_7 = `SETTLE_7_NS / `CLK_PERIOD_NS
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // register access from the serial port
  input wire logic [1:0] reg_page,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // touch detect pin
  input wire logic pen_touch_in,
  // converter
  output logic adc_power_on,
  output logic conv_start,
  output logic [3:0] conv_chan,
  output logic [1:0] conv_res,
  output logic [1:0] conv_clk_sel,
  input wire logic conv_done,
  input wire logic [11:0] conv_data,
  // panel drivers
  output logic [1:0] panel_drive,
  // page-0 result store
  output logic result_wr,
  output logic [3:0] result_idx,
  output logic [15:0] result_data,
  output logic result_available_out
);

  // a zero count would silently skip the settle wait for that code
  if (SETTLE_CYC_1 < 1 || SETTLE_CYC_2 < 1 || SETTLE_CYC_3 < 1 || SETTLE_CYC_4 < 1 ||
      SETTLE_CYC_5 < 1 || SETTLE_CYC_6 < 1 || SETTLE_CYC_7 < 1) begin : g_bad_settle
    $error("settle counts must be at least one cycle");
  end

  typedef enum logic [2:0] {S_IDLE, S_WAIT_PEN, S_REQ, S_MEAS, S_DRIVE} state_type;

  meas_if mif();

  // pen pin synchroniser
  logic pen_meta_ff, pen_sync_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pen_meta_ff <= 1'b0;
      pen_sync_ff <= 1'b0;
    end else if (ce) begin
      pen_meta_ff <= pen_touch_in;
      pen_sync_ff <= pen_meta_ff;
    end
  end

  logic pen_state_mode_bit_ff, nxt_pen_state_mode_bit;
  logic [3:0] func_ff, nxt_func;
  logic [1:0] res_ff, nxt_res;
  logic [1:0] avg_ff, nxt_avg;
  logic [1:0] clk_sel_ff, nxt_clk_sel;
  logic [2:0] pv_ff, nxt_pv;
  logic [15:0] rdata_ff, nxt_rdata;
  state_type state_ff, nxt_state;
  logic [1:0] step_ff, nxt_step;
  logic wr_ff, nxt_wr;
  logic [3:0] idx_ff, nxt_idx;
  logic [15:0] data_ff, nxt_data;
  logic avail_ff, nxt_avail;
  logic hit, wr_hit, stop_cmd, run_cmd, busy, pen_down_flag, conv_busy_stop_bit;
  logic [1:0] seq_last;
  logic continuous, last_step;
  chan_type cur_chan;

  // sequence length and channel per function code
  always_comb begin
    seq_last = 2'h0;
    cur_chan = CH_X;
    continuous = 1'b0;
    case (func_ff) // R09
      4'h1: begin
        seq_last = 2'h1;
        cur_chan = chan_type'({3'h0, step_ff[0]});
        continuous = 1'b1;
      end
      4'h2: begin
        seq_last = 2'h3;
        cur_chan = chan_type'({2'h0, step_ff});
        continuous = 1'b1;
      end
      4'h3: cur_chan = CH_X;
      4'h4: cur_chan = CH_Y;
      4'h5: begin
        seq_last = 2'h1;
        cur_chan = chan_type'({3'h1, step_ff[0]});
      end
      4'h6: cur_chan = CH_BAT1;
      4'h7: cur_chan = CH_BAT2;
      4'h8: cur_chan = CH_AUX1;
      4'h9: cur_chan = CH_AUX2;
      4'hA: cur_chan = CH_TEMP1;
      4'hB: begin
        seq_last = 2'h3;
        cur_chan = chan_type'({2'h1, step_ff});
      end
      4'hC: cur_chan = CH_TEMP2;
      default: cur_chan = CH_X;
    endcase
  end

  // register decode and read-side status
  assign hit = (reg_page == `CTRL_PAGE) && (reg_addr == `CTRL_ADDR);
  assign wr_hit = reg_wr && hit;
  assign stop_cmd = wr_hit && reg_wdata[`STS_BIT]; // R06
  assign run_cmd = wr_hit && !reg_wdata[`STS_BIT] && (reg_wdata[`FUNC_HI:`FUNC_LO] != 4'h0); // R05 R09
  assign busy = (state_ff == S_REQ) || (state_ff == S_MEAS);
  assign pen_down_flag = pen_sync_ff; // R01
  assign conv_busy_stop_bit = !busy; // R03 R04
  assign last_step = (step_ff == seq_last);

  // sub-unit request
  assign mif.req = (state_ff == S_REQ);
  assign mif.abort = stop_cmd;
  assign mif.chan = cur_chan;
  assign mif.avg_sel = avg_ff;
  assign mif.res_sel = res_ff;
  // settling only applies to touch axes in self mode
  assign mif.settle_sel = (pen_state_mode_bit_ff && cur_chan <= CH_Z2) ? pv_ff : 3'h0; // R12

  // register writes and read data
  always_comb begin
    nxt_pen_state_mode_bit = pen_state_mode_bit_ff;
    nxt_func = func_ff;
    nxt_res = res_ff;
    nxt_avg = avg_ff;
    nxt_clk_sel = clk_sel_ff;
    nxt_pv = pv_ff;
    nxt_rdata = rdata_ff;
    if (wr_hit) begin
      nxt_pen_state_mode_bit = reg_wdata[`PSM_BIT]; // R02
      nxt_func = reg_wdata[`FUNC_HI:`FUNC_LO];
      nxt_res = reg_wdata[`RES_HI:`RES_LO]; // R10
      nxt_avg = reg_wdata[`AVG_HI:`AVG_LO];
      nxt_clk_sel = reg_wdata[`CLK_HI:`CLK_LO];
      nxt_pv = reg_wdata[`PV_HI:`PV_LO];
    end
    if (reg_rd) begin
      // top two bits read back status, not the written command
      nxt_rdata = hit ? {pen_down_flag, conv_busy_stop_bit, func_ff, res_ff, avg_ff, clk_sel_ff, pv_ff, 1'b0}
                      : 16'h0000; // R08
    end
  end

  // scan sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_step = step_ff;
    nxt_wr = 1'b0;
    nxt_idx = idx_ff;
    nxt_data = data_ff;
    nxt_avail = avail_ff;
    case (state_ff)
      S_IDLE: ;
      S_WAIT_PEN: begin
        if (pen_down_flag) begin
          nxt_state = S_REQ; // R02 R12
        end
      end
      S_REQ: nxt_state = S_MEAS;
      S_MEAS: begin
        if (mif.done) begin
          nxt_wr = 1'b1;
          nxt_idx = cur_chan; // R07
          nxt_data = mif.result;
          if (!last_step) begin
            nxt_step = step_ff + 2'h1;
            nxt_state = S_REQ;
          end else begin
            nxt_step = 2'h0;
            nxt_avail = 1'b1;
            if (continuous && pen_down_flag) begin
              nxt_state = S_REQ; // R05 R13
            end else if (continuous && pen_state_mode_bit_ff) begin
              nxt_state = S_WAIT_PEN; // R13
            end else begin
              nxt_state = S_IDLE;
            end
          end
        end
      end
      S_DRIVE: ;
      default: nxt_state = S_IDLE;
    endcase
    if (run_cmd) begin
      nxt_step = 2'h0;
      nxt_avail = (state_ff == S_MEAS) && mif.done && last_step; // a finishing sequence wins over the clear
      if (reg_wdata[`FUNC_HI:`FUNC_LO] >= 4'hD) begin
        nxt_state = S_DRIVE;
      end else if (reg_wdata[`PSM_BIT]) begin
        nxt_state = S_WAIT_PEN; // R02
      end else begin
        nxt_state = S_REQ;
      end
    end
    if (stop_cmd) begin
      nxt_state = S_IDLE; // R06
      nxt_step = 2'h0;
      nxt_wr = 1'b0; // R06
      nxt_avail = avail_ff;
    end
  end

  // all state registers but the pen synchroniser
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pen_state_mode_bit_ff <= 1'b0;
      func_ff <= `FUNC_RST;
      res_ff <= `RES_RST;
      avg_ff <= `AVG_RST;
      clk_sel_ff <= `CLK_RST;
      pv_ff <= `PV_RST;
      rdata_ff <= 16'h0000;
      state_ff <= S_IDLE;
      step_ff <= 2'h0;
      wr_ff <= 1'b0;
      idx_ff <= 4'h0;
      data_ff <= 16'h0000;
      avail_ff <= 1'b0;
    end else if (ce) begin
      pen_state_mode_bit_ff <= nxt_pen_state_mode_bit;
      func_ff <= nxt_func;
      res_ff <= nxt_res;
      avg_ff <= nxt_avg;
      clk_sel_ff <= nxt_clk_sel;
      pv_ff <= nxt_pv;
      rdata_ff <= nxt_rdata;
      state_ff <= nxt_state;
      step_ff <= nxt_step;
      wr_ff <= nxt_wr;
      idx_ff <= nxt_idx;
      data_ff <= nxt_data;
      avail_ff <= nxt_avail;
    end
  end

  sample_unit #(
    .SETTLE_CYC_1(SETTLE_CYC_1),
    .SETTLE_CYC_2(SETTLE_CYC_2),
    .SETTLE_CYC_3(SETTLE_CYC_3),
    .SETTLE_CYC_4(SETTLE_CYC_4),
    .SETTLE_CYC_5(SETTLE_CYC_5),
    .SETTLE_CYC_6(SETTLE_CYC_6),
    .SETTLE_CYC_7(SETTLE_CYC_7)
  ) u_sample (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .m(mif.unit),
    .conv_start(conv_start),
    .conv_done(conv_done),
    .conv_data(conv_data)
  );

  // outputs; converter is powered only while a scan runs
  assign adc_power_on = busy; // R06
  assign conv_chan = cur_chan;
  assign conv_res = res_ff;
  assign conv_clk_sel = clk_sel_ff;
  assign reg_rdata = rdata_ff;
  assign result_wr = wr_ff;
  assign result_idx = idx_ff;
  assign result_data = data_ff;
  assign result_available_out = avail_ff;
  // touch axes drive the matching panel plates; driver codes hold them on
  always_comb begin
    panel_drive = DRV_OFF;
    if (state_ff == S_DRIVE) begin
      panel_drive = drv_type'(func_ff[1:0]);
    end else if (busy) begin // R12
      case (cur_chan)
        CH_X: panel_drive = DRV_X;
        CH_Y: panel_drive = DRV_Y;
        CH_Z1, CH_Z2: panel_drive = DRV_YX;
        default: panel_drive = DRV_OFF;
      endcase
    end
  end

endmodule : touch_adc_control

`default_nettype wire

// ### bench/touch_adc_control_props.sv
// touch_adc_control_props: port-level timing relations of the converter control block
// assumes: bound to touch_adc_control, one clock domain, reset async active low
`timescale 1ns/1ns
`default_nettype none

module touch_adc_control_props (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // register port
  input wire logic [1:0] reg_page,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // pin and converter side
  input wire logic pen_touch_in,
  input wire logic adc_power_on,
  input wire logic conv_start,
  input wire logic [1:0] conv_res,
  input wire logic result_wr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // access aimed at the control word
  logic hit;
  assign hit = ce && reg_page == 2'h1 && reg_addr == 6'h00;

  a_stop_powers_down: assert property (hit && reg_wr && reg_wdata[14] |=> !adc_power_on)
    else $error("converter still powered after stop");
  a_func_zero_idle: assert property (hit && reg_wr && reg_wdata[14:10] == 5'h00 && !adc_power_on
    |=> !adc_power_on [*2])
    else $error("invalid function started the converter");
  a_start_powered: assert property (conv_start |-> adc_power_on)
    else $error("start pulse while converter off");
  a_result_one_pulse: assert property (result_wr |=> !result_wr)
    else $error("result write longer than one cycle");
  a_busy_reads_zero: assert property (hit && reg_rd && adc_power_on |=> !reg_rdata[14])
    else $error("status bit not zero while busy");
  a_spare_bit_zero: assert property (reg_rd |=> !reg_rdata[0])
    else $error("spare bit read as one");
  a_unmapped_zero: assert property (ce && reg_rd && !(reg_page == 2'h1 && reg_addr == 6'h00)
    |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_res_follows: assert property (hit && reg_wr |=> conv_res == $past(reg_wdata[9:8]))
    else $error("resolution select does not follow write");
  a_pen_reads_pin: assert property (hit && reg_rd && $stable(pen_touch_in)
    && pen_touch_in == $past(pen_touch_in, 2) && pen_touch_in == $past(pen_touch_in, 3)
    |=> reg_rdata[15] == $past(pen_touch_in))
    else $error("pen bit differs from settled pin");
endmodule : touch_adc_control_props

`default_nettype wire

// ### bench/adc_model.sv
// adc_model: converter stand-in answering each start pulse after a short or long wait
// assumes: dropping power cancels a pending conversion; data line is junk between answers
`timescale 1ns/1ns
`default_nettype none

module adc_model (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control from the block
  input wire logic power,
  input wire logic start,
  // bench settings
  input wire logic slow,
  input wire logic [11:0] val,
  // answer
  output logic done,
  output logic [11:0] data
);
  int wait_ff;
  logic [11:0] last_ff;

  // one start gives exactly one done unless power drops or another start comes first
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_ff <= 0;
      done <= 1'b0;
      data <= 12'hFFF;
      last_ff <= 12'h000;
    end else begin
      done <= 1'b0;
      data <= ~last_ff;  // never leave a stale value that could pass for a sample
      if (!power) wait_ff <= 0;
      else if (start) wait_ff <= slow ? 5 : 1;
      else if (wait_ff == 1) begin
        done <= 1'b1;
        data <= val;
        last_ff <= val;
        wait_ff <= 0;
      end else if (wait_ff > 1) wait_ff <= wait_ff - 1;
    end
  end
endmodule : adc_model

`default_nettype wire

// ### bench/test_touch_adc_control.sv
// test_touch_adc_control: self-checking bench for the converter control block
// assumes: adc_model answers every start; settle counts shortened to 1..7 cycles
`timescale 1ns/1ns
`default_nettype none

module test_touch_adc_control;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [1:0] reg_page = 2'h0;
  logic [5:0] reg_addr = 6'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic pen_touch_in = 1'b0;
  logic slow = 1'b0;
  logic [11:0] val = 12'h000;
  logic [15:0] reg_rdata, result_data;
  logic adc_power_on, conv_start, conv_done, result_wr, result_available_out;
  logic [3:0] conv_chan, result_idx;
  logic [1:0] conv_res, conv_clk_sel, panel_drive;
  logic [11:0] conv_data;
  logic [3:0] qi[$];
  logic [15:0] qd[$];
  int n_fail = 0;
  int checks_done = 0;
  int n_start = 0;
  int cyc = 0;
  int t_drv = -1;
  int t_go = -1;
  integer seed = 32'hdf057208;
  int first_idx [3:12] = '{0, 1, 2, 4, 5, 6, 7, 8, 4, 9};
  int n_of [3:12] = '{1, 1, 2, 1, 1, 1, 1, 1, 4, 1};

  always #10 clk = ~clk;

  // design with short settle counts, converter model on its far side
  touch_adc_control #(.SETTLE_CYC_1(1), .SETTLE_CYC_2(2), .SETTLE_CYC_3(3), .SETTLE_CYC_4(4),
    .SETTLE_CYC_5(5), .SETTLE_CYC_6(6), .SETTLE_CYC_7(7)) u_dut (
    .clk(clk), .resetn(resetn), .ce(ce), .reg_page(reg_page), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pen_touch_in(pen_touch_in),
    .adc_power_on(adc_power_on), .conv_start(conv_start), .conv_chan(conv_chan), .conv_res(conv_res),
    .conv_clk_sel(conv_clk_sel), .conv_done(conv_done), .conv_data(conv_data), .panel_drive(panel_drive),
    .result_wr(result_wr), .result_idx(result_idx), .result_data(result_data),
    .result_available_out(result_available_out));
  adc_model u_adc (.clk(clk), .resetn(resetn), .power(adc_power_on), .start(conv_start), .slow(slow),
    .val(val), .done(conv_done), .data(conv_data));

  // log result writes, count starts, stamp first panel drive and first start
  always @(posedge clk) begin
    cyc++;
    if (result_wr === 1'b1) begin
      qi.push_back(result_idx);
      qd.push_back(result_data);
    end
    if (conv_start === 1'b1) begin
      n_start++;
      if (t_go < 0) t_go = cyc;
    end
    if (panel_drive !== 2'h0 && t_drv < 0) t_drv = cyc;
  end

  // expected result: averaging of equal samples keeps the sample, then trim
  function automatic logic [15:0] exp_res(input logic [11:0] v, input logic [1:0] rs);
    if (rs == 2'h1) return {8'h00, v[11:4]};
    if (rs == 2'h2) return {6'h00, v[11:2]};
    return {4'h0, v};
  endfunction : exp_res

  function automatic int nconv(input logic [1:0] av);
    return (av == 2'h0) ? 1 : (2 << av);
  endfunction : nconv

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  task automatic chkn(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkn

  // all drives land 2 ns after an edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick

  task automatic wr(input logic [15:0] d);
    tick(1);
    reg_page = 2'h1;
    reg_addr = 6'h00;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] pg, input logic [5:0] ad, output logic [15:0] q);
    tick(1);
    reg_page = pg;
    reg_addr = ad;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    q = reg_rdata;
  endtask : rd

  task automatic wait_res(input int n);
    int k;
    k = 0;
    while (qi.size() < n && k < 3000) begin
      tick(1);
      k++;
    end
    chkn(qi.size() >= n, 1);
  endtask : wait_res

  task automatic go_idle();
    int k;
    k = 0;
    while (adc_power_on !== 1'b0 && k < 3000) begin
      tick(1);
      k++;
    end
    tick(4);
    chk16(adc_power_on, 16'h0000);
  endtask : go_idle

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // cut a hang short; the whole sequence needs far fewer cycles
  initial begin
    #1000000;
    n_fail++;
    final_report();
  end

  // main sequence
  initial begin
    logic [15:0] q;
    logic [15:0] cmd;
    logic [31:0] rnd;
    logic [1:0] rs;
    logic [1:0] av;
    logic [2:0] pv;
    tick(3);
    resetn = 1'b1;
    rd(2'h1, 6'h00, q);
    chk16(q, 16'h4000);
    rd(2'h1, 6'h01, q);
    chk16(q, 16'h0000);
    // invalid function keeps its fields but converts nothing
    rnd = $random(seed);
    cmd = {6'h00, rnd[1:0], 8'h00};
    wr(cmd);
    tick(20);
    chkn(n_start + qi.size(), 0);
    rd(2'h1, 6'h00, q);
    chk16(q, cmd | 16'h4000);
    // each single-shot function in host mode with random resolution, averaging and data; the random settle field is never applied
    pen_touch_in = 1'b1;
    for (int f = 3; f <= 12; f++) begin
      rnd = $random(seed);
      slow = rnd[19];
      val = rnd[18:7];
      pv = rnd[6:4];
      av = rnd[3:2];
      rs = rnd[1:0];
      cmd = {2'b00, f[3:0], rs, av, 2'h2, pv, 1'b0};
      qi.delete();
      qd.delete();
      n_start = 0;
      wr(cmd);
      rd(2'h1, 6'h00, q);
      chk16(q[14], 16'h0000);
      go_idle();
      chkn(qi.size(), n_of[f]);
      for (int i = 0; i < qi.size(); i++) begin
        chk16(qi[i], 16'(first_idx[f] + i));
        chk16(qd[i], exp_res(val, rs));
      end
      chkn(n_start, n_of[f] * nconv(av));
      chk16(result_available_out, 16'h0001);
      rd(2'h1, 6'h00, q);
      chk16(q, cmd | 16'hC000);
    end
    // host scan alternates X and Y while touched; stop cuts it off
    qi.delete();
    wr(16'h0400);
    wait_res(6);
    for (int i = 0; i < 6; i++) chk16(qi[i], 16'(i % 2));
    wr(16'h4000);
    n_start = 0;
    qi.delete();
    tick(30);
    chkn(n_start + qi.size(), 0);
    rd(2'h1, 6'h00, q);
    chk16(q, 16'hC000);
    // lifting the pen ends a host scan
    wr(16'h0400);
    wait_res(2);
    pen_touch_in = 1'b0;
    go_idle();
    n_start = 0;
    tick(30);
    chkn(n_start, 0);
    // self-timed scan waits for touch, drives the panel and settles first
    t_drv = -1;
    t_go = -1;
    n_start = 0;
    qi.delete();
    wr(16'h8426);
    tick(30);
    chkn(n_start, 0);
    // enable low freezes even the pen synchroniser, so a touch now starts nothing
    ce = 1'b0;
    pen_touch_in = 1'b1;
    tick(10);
    chkn(n_start + int'(adc_power_on), 0);
    ce = 1'b1;
    wait_res(4);
    chkn(t_go - t_drv >= 3, 1);
    pen_touch_in = 1'b0;
    tick(40);
    n_start = 0;
    tick(40);
    chkn(n_start, 0);
    pen_touch_in = 1'b1;
    qi.delete();
    wait_res(1);
    wr(16'h4000);
    go_idle();
    final_report();
  end
endmodule : test_touch_adc_control

bind touch_adc_control touch_adc_control_props u_props (.clk(clk), .resetn(resetn), .ce(ce),
  .reg_page(reg_page), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .pen_touch_in(pen_touch_in), .adc_power_on(adc_power_on),
  .conv_start(conv_start), .conv_res(conv_res), .result_wr(result_wr));

`default_nettype wire
